// ===== rcc_pkg.sv
// package for the receiver common configuration register bank
// assumes a classic wishbone slave with 32-bit data, one register per word
package rcc_pkg;

  // register indices (byte address is four times the index)
  localparam logic [3:0] IDX_BUFFER      = 4'h0;
  localparam logic [3:0] IDX_OPSTATE     = 4'h1;
  localparam logic [3:0] IDX_PROCKEY     = 4'h2;
  localparam logic [3:0] IDX_RATE_HI     = 4'h3;
  localparam logic [3:0] IDX_RATE_LO     = 4'h4;
  localparam logic [3:0] IDX_RSV5        = 4'h5;
  localparam logic [3:0] IDX_RSV6        = 4'h6;
  localparam logic [3:0] IDX_CARRIER_HI  = 4'h7;
  localparam logic [3:0] IDX_CARRIER_MID = 4'h8;
  localparam logic [3:0] IDX_CARRIER_LO  = 4'h9;
  localparam logic [3:0] IDX_OSC_TRIM    = 4'hA;
  localparam logic [3:0] IDX_LAST        = 4'hA;

  // field positions
  localparam int SEQ_DIS_BIT    = 7;
  localparam int LISTEN_EN_BIT  = 6;
  localparam int LISTEN_CAN_BIT = 5;
  localparam int STATE_LSB      = 2;
  localparam int PROC_LSB       = 5;
  localparam int KEY_LSB        = 3;
  localparam int TRIM_TRIG_BIT  = 7;
  localparam int TRIM_DONE_BIT  = 6;

  // reset values
  localparam logic [7:0] RST_RATE_HI     = 8'h1A;
  localparam logic [7:0] RST_RATE_LO     = 8'h0B;
  localparam logic [7:0] RST_RSV5        = 8'h00;
  localparam logic [7:0] RST_RSV6        = 8'h52;
  localparam logic [7:0] RST_CARRIER_HI  = 8'hE4;
  localparam logic [7:0] RST_CARRIER_MID = 8'hC0;
  localparam logic [7:0] RST_CARRIER_LO  = 8'h00;
  localparam logic [5:0] RST_TRIM_LOW    = 6'h01;

  // timing
  localparam int CLK_MHZ       = 200;
  localparam int TRIM_TIME_US  = 10;
  localparam int TRIM_CYCLES   = TRIM_TIME_US * CLK_MHZ;
  localparam int STATE_SETTLE  = 4;

  typedef enum logic [2:0] {
    ST_SLEEP   = 3'h0,
    ST_STANDBY = 3'h1,
    ST_SYNTH   = 3'h2,
    ST_RECEIVE = 3'h4
  } rcc_state_type;

  typedef enum logic [1:0] {
    PROC_PACKET   = 2'h0,
    PROC_RSV      = 2'h1,
    PROC_CONT_SYN = 2'h2,
    PROC_CONT_RAW = 2'h3
  } rcc_proc_type;

  typedef enum logic [1:0] {
    KEY_FSK  = 2'h0,
    KEY_OOK  = 2'h1,
    KEY_RSV2 = 2'h2,
    KEY_RSV3 = 2'h3
  } rcc_key_type;

  typedef struct packed {
    rcc_proc_type processing_select;
    rcc_key_type  keying_select;
    logic [15:0]  rate_divisor;
    logic [23:0]  carrier_word;
    logic         listen_active;
    logic         auto_sequencer_disable;
  } rcc_cfg_type;

endpackage

// ===== rcc_regs.sv
// receiver common configuration register bank, wishbone classic slave
// assumes buffer bytes arrive with valid/ready; calibration engine is a counter
//
// Operation
// - sequencer steps toward selected state automatically
// - disabled sequencer takes written state at once
// - cancel with listen off aborts; reads zero
// - state codes sleep standby synth receive, reset standby
// - state field reads actual current state
// - processing select packet or continuous modes
// - keying select fsk or ook, reset fsk
// - divisor split high/low; chip rate with manchester
// - data rate is crystal over divisor
// - carrier word 24 bits, three bytes
// - trigger bit starts oscillator calibration, reads zero
// - reset reloads every register default
// - complete flag low while calibrating, reset one
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module rcc_regs #(
  parameter int TRIM_CYCLES = rcc_pkg::TRIM_CYCLES,
  parameter int SETTLE      = rcc_pkg::STATE_SETTLE
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [5:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  input  wire logic [7:0]        rx_byte_i,
  input  wire logic              rx_valid_i,
  output logic                   rx_ready_o,
  input  wire logic              listen_done_i,
  output rcc_pkg::rcc_cfg_type   cfg_o,
  output rcc_pkg::rcc_state_type state_o,
  output logic                   trim_busy_o
);

  logic                   seq_dis_r;
  logic                   listen_r;
  rcc_pkg::rcc_state_type target_r;
  rcc_pkg::rcc_state_type state_r;
  rcc_pkg::rcc_state_type state_nxt;
  rcc_pkg::rcc_proc_type  proc_r;
  rcc_pkg::rcc_key_type   key_r;
  logic [15:0]            rate_r;
  logic [23:0]            carrier_r;
  logic [15:0]            trim_cnt_r;
  logic                   trim_busy_r;
  logic [7:0]             settle_r;
  logic                   ack_r;
  logic                   err_r;
  logic [31:0]            rdata_r;
  logic [7:0]             rdata_nxt;

  // bus decode
  wire        req      = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  wire [3:0]  idx      = wb_adr_i[5:2];
  wire        mapped   = (wb_adr_i[1:0] == 2'h0) && (idx <= rcc_pkg::IDX_LAST);
  wire        wr_ok    = req && mapped && wb_we_i && wb_sel_i[0];
  wire        rd_ok    = req && mapped && !wb_we_i;
  wire [7:0]  wd       = wb_dat_i[7:0];
  wire        wr_op    = wr_ok && (idx == rcc_pkg::IDX_OPSTATE);
  wire        wr_pk    = wr_ok && (idx == rcc_pkg::IDX_PROCKEY);
  wire        wr_osc   = wr_ok && (idx == rcc_pkg::IDX_OSC_TRIM);
  wire        pop      = rd_ok && (idx == rcc_pkg::IDX_BUFFER);
  wire        cancel   = wr_op && wd[rcc_pkg::LISTEN_CAN_BIT] && !wd[rcc_pkg::LISTEN_EN_BIT];
  wire        trim_go  = wr_osc && wd[rcc_pkg::TRIM_TRIG_BIT];
  wire [2:0]  wr_state = wd[rcc_pkg::STATE_LSB +: 3];
  wire        st_legal = (wr_state == 3'h0) || (wr_state == 3'h1) || (wr_state == 3'h2) || (wr_state == 3'h4);

  // byte pop handshake, one byte per read
  assign rx_ready_o = pop;

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    if (wr_op && wd[rcc_pkg::SEQ_DIS_BIT] && st_legal) begin
      state_nxt = rcc_pkg::rcc_state_type'(wr_state);
    end else if (!seq_dis_r && state_r != target_r && settle_r == 8'h00) begin
      case (state_r)
        rcc_pkg::ST_SLEEP:   state_nxt = rcc_pkg::ST_STANDBY;
        rcc_pkg::ST_STANDBY: state_nxt = (target_r == rcc_pkg::ST_SLEEP) ? rcc_pkg::ST_SLEEP : rcc_pkg::ST_SYNTH;
        rcc_pkg::ST_SYNTH:   state_nxt = (target_r == rcc_pkg::ST_RECEIVE) ? rcc_pkg::ST_RECEIVE
                                                                          : rcc_pkg::ST_STANDBY;
        rcc_pkg::ST_RECEIVE: state_nxt = rcc_pkg::ST_SYNTH;
        default:             state_nxt = rcc_pkg::ST_STANDBY;
      endcase
    end
  end

  // register read mux
  always_comb begin
    rdata_nxt = 8'h00;
    case (idx)
      rcc_pkg::IDX_BUFFER:      rdata_nxt = rx_valid_i ? rx_byte_i : 8'h00;
      rcc_pkg::IDX_OPSTATE:     rdata_nxt = {seq_dis_r, listen_r, 1'b0, state_r, 2'b00};
      rcc_pkg::IDX_PROCKEY:     rdata_nxt = {1'b0, proc_r, key_r, 3'b000};
      rcc_pkg::IDX_RATE_HI:     rdata_nxt = rate_r[15:8];
      rcc_pkg::IDX_RATE_LO:     rdata_nxt = rate_r[7:0];
      rcc_pkg::IDX_RSV5:        rdata_nxt = rcc_pkg::RST_RSV5;
      rcc_pkg::IDX_RSV6:        rdata_nxt = rcc_pkg::RST_RSV6;
      rcc_pkg::IDX_CARRIER_HI:  rdata_nxt = carrier_r[23:16];
      rcc_pkg::IDX_CARRIER_MID: rdata_nxt = carrier_r[15:8];
      rcc_pkg::IDX_CARRIER_LO:  rdata_nxt = carrier_r[7:0];
      rcc_pkg::IDX_OSC_TRIM:    rdata_nxt = {1'b0, !trim_busy_r, rcc_pkg::RST_TRIM_LOW};
      default:                  rdata_nxt = 8'h00;
    endcase
  end

  // bus answer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req && mapped;
      err_r   <= req && !mapped;
      rdata_r <= rd_ok ? {24'h00_0000, rdata_nxt} : 32'h0000_0000;
    end
  end

  // operating state control
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seq_dis_r <= 1'b0;
      listen_r  <= 1'b0;
      target_r  <= rcc_pkg::ST_STANDBY;
      state_r   <= rcc_pkg::ST_STANDBY;
      settle_r  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        settle_r <= 8'(SETTLE);
      end else if (settle_r != 8'h00) begin
        settle_r <= settle_r - 8'h01;
      end
      if (wr_op) begin
        seq_dis_r <= wd[rcc_pkg::SEQ_DIS_BIT];
        listen_r  <= wd[rcc_pkg::LISTEN_EN_BIT];
        if (st_legal) begin
          target_r <= rcc_pkg::rcc_state_type'(wr_state);
        end
      end else if (listen_done_i) begin
        listen_r <= 1'b0;
      end
      if (cancel) begin
        target_r <= rcc_pkg::ST_STANDBY;
      end
    end
  end

  // data path configuration
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      proc_r    <= rcc_pkg::PROC_PACKET;
      key_r     <= rcc_pkg::KEY_FSK;
      rate_r    <= {rcc_pkg::RST_RATE_HI, rcc_pkg::RST_RATE_LO};
      carrier_r <= {rcc_pkg::RST_CARRIER_HI, rcc_pkg::RST_CARRIER_MID, rcc_pkg::RST_CARRIER_LO};
    end else begin
      if (wr_pk) begin
        proc_r <= rcc_pkg::rcc_proc_type'(wd[rcc_pkg::PROC_LSB +: 2]);
        key_r  <= rcc_pkg::rcc_key_type'(wd[rcc_pkg::KEY_LSB +: 2]);
      end
      if (wr_ok && idx == rcc_pkg::IDX_RATE_HI) begin
        rate_r[15:8] <= wd;
      end
      if (wr_ok && idx == rcc_pkg::IDX_RATE_LO) begin
        rate_r[7:0] <= wd;
      end
      if (wr_ok && idx == rcc_pkg::IDX_CARRIER_HI) begin
        carrier_r[23:16] <= wd;
      end
      if (wr_ok && idx == rcc_pkg::IDX_CARRIER_MID) begin
        carrier_r[15:8] <= wd;
      end
      if (wr_ok && idx == rcc_pkg::IDX_CARRIER_LO) begin
        carrier_r[7:0] <= wd;
      end
    end
  end

  // oscillator calibration timer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trim_busy_r <= 1'b0;
      trim_cnt_r  <= 16'h0000;
    end else if (trim_go) begin
      trim_busy_r <= 1'b1;
      trim_cnt_r  <= 16'(TRIM_CYCLES - 1);
    end else if (trim_busy_r) begin
      if (trim_cnt_r == 16'h0000) begin
        trim_busy_r <= 1'b0;
      end else begin
        trim_cnt_r <= trim_cnt_r - 16'h0001;
      end
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_err_o    = err_r;
  assign wb_dat_o    = rdata_r;
  assign state_o     = state_r;
  assign trim_busy_o = trim_busy_r;
  // divisor feeds rate generator: rate = crystal_frequency / rate_divisor
  assign cfg_o       = '{processing_select:      proc_r,
                         keying_select:          key_r,
                         rate_divisor:           rate_r,
                         carrier_word:           carrier_r,
                         listen_active:          listen_r,
                         auto_sequencer_disable: seq_dis_r};

endmodule // rcc_regs

// ===== rcc_regs_props.sv
// port assertions for the register bank
// bound to rcc_regs; sees its ports only
`timescale 1ns/1ps
module rcc_regs_props #(parameter int TRIM_CYCLES = 5) (
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [5:0]             wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   wb_err_o,
  input wire logic [7:0]             rx_byte_i,
  input wire logic                   rx_ready_o,
  input wire rcc_pkg::rcc_cfg_type   cfg_o,
  input wire rcc_pkg::rcc_state_type state_o,
  input wire logic                   trim_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire wr0  = take && wb_we_i && wb_sel_i[0];
  int busy_cnt;
  // cycles of calibration since the last trigger
  always_ff @(posedge clk_i) begin
    if (reset_i || (wr0 && wb_adr_i == 6'h28 && wb_dat_i[7])) busy_cnt <= 0;
    else if (trim_busy_o) busy_cnt <= busy_cnt + 1;
  end
  sequence rd_at(logic [5:0] a); take && !wb_we_i && wb_adr_i == a; endsequence
  sequence wr_at(logic [5:0] a); wr0 && wb_adr_i == a; endsequence
  a_one_answer: assert property (take |=> wb_ack_o != wb_err_o) else $error("request not answered once");
  a_unmapped_err: assert property (take && (wb_adr_i[1:0] != 2'h0 || wb_adr_i[5:2] > 4'hA) |=> wb_err_o)
    else $error("unmapped access not refused");
  a_state_legal: assert property (state_o inside {3'h0, 3'h1, 3'h2, 3'h4}) else $error("reserved state");
  a_reset_standby: assert property ($past(reset_i) |-> state_o == 3'h1 && !trim_busy_o)
    else $error("state after reset");
  a_forced_state: assert property (wr_at(6'h04) ##0 wb_dat_i[7] && wb_dat_i[4:2] inside {3'h0, 3'h1, 3'h2, 3'h4}
    |=> state_o == $past(wb_dat_i[4:2])) else $error("forced state not taken");
  a_state_read: assert property (rd_at(6'h04) |=> wb_dat_o == {24'h0, $past(cfg_o.auto_sequencer_disable),
    $past(cfg_o.listen_active), 1'b0, $past(state_o), 2'h0}) else $error("state read wrong");
  a_trim_read: assert property (rd_at(6'h28) |=> wb_dat_o == {25'h0, !$past(trim_busy_o), 6'h01})
    else $error("trim read wrong");
  a_trim_start: assert property (wr_at(6'h28) ##0 wb_dat_i[7] |=> trim_busy_o) else $error("trim not started");
  a_trim_len: assert property (trim_busy_o |-> busy_cnt <= TRIM_CYCLES) else $error("trim too long");
  a_pop_byte: assert property (rx_ready_o |-> rd_at(6'h00) ##1 wb_ack_o && wb_dat_o == {24'h0, $past(rx_byte_i)})
    else $error("buffer pop wrong");
  a_rsv_fixed: assert property (rd_at(6'h18) |=> wb_dat_o == 32'h52) else $error("reserved read wrong");
  a_rate_write: assert property (wr_at(6'h0C) |=> cfg_o.rate_divisor[15:8] == $past(wb_dat_i[7:0]))
    else $error("divisor high not written");
  a_carrier_write: assert property (wr_at(6'h24) |=> cfg_o.carrier_word[7:0] == $past(wb_dat_i[7:0]))
    else $error("carrier low not written");
endmodule // rcc_regs_props
bind rcc_regs rcc_regs_props #(.TRIM_CYCLES(TRIM_CYCLES)) u_props (.*);

// ===== rcc_regs_tb_top.sv
// self-checking bench for the register bank
// drives the wishbone and receive ports directly
`timescale 1ns/1ps
module rcc_regs_tb_top;
  logic                   clk_i = 0, reset_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0]             wb_adr_i = 0;
  logic [3:0]             wb_sel_i = 4'hF;
  logic [31:0]            wb_dat_i = 0, wb_dat_o;
  logic [7:0]             rx_byte_i = 0, v;
  logic                   rx_valid_i = 0, listen_done_i = 0, wb_ack_o, wb_err_o, rx_ready_o, trim_busy_o;
  rcc_pkg::rcc_cfg_type   cfg_o;
  rcc_pkg::rcc_state_type state_o;
  logic [32:0]            exp_q[$];
  logic [7:0]             mem [3:9];
  logic [7:0]             rst [1:10] = '{8'h04, 8'h00, 8'h1A, 8'h0B, 8'h00, 8'h52, 8'hE4, 8'hC0, 8'h00, 8'h41};
  int                     failures = 0, n_compared = 0, seed = 32'h7C5C, n_pop = 0;
  rcc_regs #(.TRIM_CYCLES(5)) dut (.*);
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while ((wb_ack_o | wb_err_o) !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d); xfer(1, a, d, 33'h0); endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e); xfer(0, a, 8'h00, {25'h0, e}); endtask
  task automatic test_done;
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // answer checker: oldest note against each ack or err
  always @(posedge clk_i) begin
    if ((wb_ack_o | wb_err_o) === 1'b1) chk({wb_err_o, wb_dat_o}, exp_q.pop_front());
  end
  // pop strobes seen on the receive port
  always @(posedge clk_i) begin
    if (rx_ready_o === 1'b1) n_pop++;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 0;
    @(posedge clk_i);
    for (int i = 1; i <= 10; i++) rd(6'(i * 4), rst[i]);
    chk(cfg_o, {4'h0, 16'h1A0B, 24'hE4C000, 2'h0});
    for (int i = 3; i <= 9; i++) begin
      v = $random(seed);
      mem[i] = v;
      wr(6'(i * 4), v);
      rd(6'(i * 4), (i == 5 || i == 6) ? rst[i] : v);
    end
    chk(cfg_o.rate_divisor, {mem[3], mem[4]});
    chk(cfg_o.carrier_word, {mem[7], mem[8], mem[9]});
    for (int p = 0; p < 4; p++) for (int k = 0; k < 2; k++) if (p != 1) begin
      wr(6'h08, {1'b1, 2'(p), 2'(k), 3'h7});
      rd(6'h08, {1'b0, 2'(p), 2'(k), 3'h0});
      chk({cfg_o.processing_select, cfg_o.keying_select}, {2'(p), 2'(k)});
    end
    wr(6'h04, 8'h90);
    chk(state_o, rcc_pkg::ST_RECEIVE);
    rd(6'h04, 8'h90);
    wr(6'h04, 8'h00);
    chk(state_o === rcc_pkg::ST_SLEEP, 0);
    repeat (20) @(posedge clk_i);
    rd(6'h04, 8'h00);
    wr(6'h04, 8'h84);
    wr(6'h04, 8'h8C);
    rd(6'h04, 8'h84);
    wr(6'h04, 8'hC4);
    rd(6'h04, 8'hC4);
    wr(6'h04, 8'hA4);
    rd(6'h04, 8'h84);
    wr(6'h04, 8'hC4);
    listen_done_i <= 1;
    @(posedge clk_i);
    listen_done_i <= 0;
    @(posedge clk_i);
    chk(cfg_o.listen_active, 0);
    wr(6'h28, 8'hFF);
    chk(trim_busy_o, 1);
    rd(6'h28, 8'h01);
    repeat (10) @(posedge clk_i);
    rd(6'h28, 8'h41);
    xfer(0, 6'h2C, 8'h00, {1'b1, 32'h0});
    xfer(1, 6'h05, 8'hFF, {1'b1, 32'h0});
    rx_valid_i <= 1;
    repeat (2) begin
      v = $random(seed);
      rx_byte_i <= v;
      rd(6'h00, v);
    end
    chk(n_pop, 2);
    reset_i <= 1;
    repeat (2) @(posedge clk_i);
    reset_i <= 0;
    @(posedge clk_i);
    wb_sel_i <= 4'hE;
    wr(6'h0C, 8'h55);
    wb_sel_i <= 4'hF;
    rd(6'h0C, 8'h1A);
    rd(6'h04, 8'h04);
    test_done();
  end
endmodule // rcc_regs_tb_top
